//--- logic/isf_pkg.sv
package isf_pkg;

    // ------------------------------------------------------------
    // Register offsets on the host port
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_STATUS   = 8'h58;
    localparam logic [7:0]  OFS_ENABLE   = 8'h5c;
    localparam logic [7:0]  OFS_BYTETEST = 8'h64;

    // ------------------------------------------------------------
    // Flag bit positions
    // ------------------------------------------------------------
    localparam int BIT_SW      = 31;
    localparam int BIT_TXSTOP  = 25;
    localparam int BIT_RXSTOP  = 24;
    localparam int BIT_DROPMID = 23;
    localparam int BIT_TXDONE  = 21;
    localparam int BIT_RXXFER  = 20;
    localparam int BIT_TIMER   = 19;
    localparam int BIT_PHY     = 18;
    localparam int BIT_POWER   = 17;
    localparam int BIT_TSOVF   = 16;
    localparam int BIT_OVSIZE  = 15;
    localparam int BIT_RXERR   = 14;
    localparam int BIT_TXERR   = 13;
    localparam int BIT_TDOVR   = 10;
    localparam int BIT_TDAVAIL = 9;
    localparam int BIT_TSFULL  = 8;
    localparam int BIT_TSLEVEL = 7;
    localparam int BIT_RXDROP  = 6;
    localparam int BIT_RSFULL  = 4;
    localparam int BIT_RSLEVEL = 3;
    localparam int BIT_GPIO0   = 0;

    // ------------------------------------------------------------
    // Masks, reset values and constants
    // ------------------------------------------------------------
    localparam logic [31:0] MASK_IMPL     = 32'h83bfe7df;
    localparam logic [31:0] MASK_CLEAR    = 32'h83bbe7df;
    localparam logic [31:0] RST_STATUS    = 32'h00000000;
    localparam logic [31:0] RST_ENABLE    = 32'h00000000;
    localparam logic [31:0] BYTETEST_VAL  = 32'h87654321;
    localparam logic [31:0] DROP_BELOW    = 32'h7fffffff;
    localparam logic [31:0] DROP_MIDPOINT = 32'h80000000;
    localparam logic [15:0] TIMER_ZERO    = 16'h0000;
    localparam logic [15:0] TIMER_WRAP    = 16'hffff;
    localparam logic [13:0] OVERSIZE_LEN  = 14'h0800;

    // ------------------------------------------------------------
    // Carried groups
    // ------------------------------------------------------------
    typedef struct packed {
        logic        cs;
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } isf_bus_t;

    typedef struct packed {
        logic        stop_tx_req;
        logic        tx_halted;
        logic        rx_halted;
        logic [31:0] drop_count;
        logic        tx_done_marked;
        logic        rx_xfer_done;
        logic [15:0] timer_count;
        logic        phy_event;
        logic        power_event;
        logic        ts_overflow;
        logic        rx_frame_end;
        logic [13:0] rx_frame_len;
        logic        rx_error;
        logic        tx_error;
        logic        td_write;
        logic        td_full;
        logic [7:0]  td_free;
        logic [7:0]  td_level;
        logic        ts_full;
        logic [7:0]  ts_used;
        logic [7:0]  ts_level;
        logic        rx_dropped;
        logic        rs_full;
        logic [7:0]  rs_used;
        logic [7:0]  rs_level;
        logic [2:0]  gpio_event;
    } isf_events_t;

endpackage

//--- logic/isf_flag_bank.sv
`timescale 1ns/1ns
module isf_flag_bank
#(
    parameter int          WIDTH = 32,
    parameter logic [31:0] MASK  = 32'hffffffff
)
(
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Set and clear vectors
    input  wire logic [WIDTH-1:0] set_vec,
    input  wire logic [WIDTH-1:0] clr_vec,
    // Sticky flags
    output logic      [WIDTH-1:0] flags
);

    // ------------------------------------------------------------
    // One sticky flag per bit set in MASK, other bits tied low; set beats clear
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_flag
            if (MASK[i])
            begin : g_live
                always_ff @(posedge clock or posedge rst)
                begin
                    if (rst)
                        flags[i] <= 1'b0;
                    else
                        flags[i] <= set_vec[i] |
                                    (flags[i] & ~clr_vec[i]);
                end
            end
            else
            begin : g_dead
                assign flags[i] = 1'b0;
            end
        end
    endgenerate

endmodule

//--- logic/isf_status.sv
`timescale 1ns/1ns
module isf_status
(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                rst,
    // Host register port
    input  wire isf_pkg::isf_bus_t    bus,
    output logic             [31:0]  rdata,
    // Event sources
    input  wire isf_pkg::isf_events_t ev,
    // Power state
    input  wire logic                low_power,
    output logic                     wake_request,
    // Interrupt requests
    output logic                     master_irq,
    output logic                     held_irq,
    output logic                     power_irq
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0] status;
    logic [31:0] enable_r;
    logic [31:0] enable_nxt;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [31:0] status_view;
    logic [31:0] rdata_nxt;
    logic        rx_halted_r;
    logic        tx_stop_r;
    logic [31:0] drop_prev_r;
    logic [15:0] timer_prev_r;
    logic        phy_r;
    logic        wr_status;
    logic        wr_enable;
    logic        wr_bytetest;
    logic        tx_stop_now;
    logic        any_enabled;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Write strobes per register
    assign wr_status   = bus.cs & bus.wr &
                         (bus.addr == isf_pkg::OFS_STATUS);
    assign wr_enable   = bus.cs & bus.wr &
                         (bus.addr == isf_pkg::OFS_ENABLE);
    assign wr_bytetest = bus.cs & bus.wr &
                         (bus.addr == isf_pkg::OFS_BYTETEST);

    // ------------------------------------------------------------
    // Enable register
    // ------------------------------------------------------------
    // Reserved bits never stored
    assign enable_nxt = bus.wdata & isf_pkg::MASK_IMPL;

    // Mask register, plain read/write
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            enable_r <= isf_pkg::RST_ENABLE;
        else if (wr_enable)
            enable_r <= enable_nxt;
    end

    // ------------------------------------------------------------
    // Edge history for source signals
    // ------------------------------------------------------------
    assign tx_stop_now = ev.stop_tx_req & ev.tx_halted;

    // Previous values for edge and wrap detection
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rx_halted_r  <= 1'b0;
            tx_stop_r    <= 1'b0;
            drop_prev_r  <= 32'h00000000;
            timer_prev_r <= isf_pkg::TIMER_WRAP; // No false wrap at release
        end
        else
        begin
            rx_halted_r  <= ev.rx_halted;
            tx_stop_r    <= tx_stop_now;
            drop_prev_r  <= ev.drop_count;
            timer_prev_r <= ev.timer_count;
        end
    end

    // Transceiver event mirrored, not sticky
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            phy_r <= 1'b0;
        else
            phy_r <= ev.phy_event;
    end

    // ------------------------------------------------------------
    // Set vector, independent of the mask except for the software bit
    // ------------------------------------------------------------
    always_comb
    begin
        set_vec = 32'h00000000;
        set_vec[isf_pkg::BIT_SW] = wr_enable &
            bus.wdata[isf_pkg::BIT_SW] &
            ~enable_r[isf_pkg::BIT_SW];
        set_vec[isf_pkg::BIT_TXSTOP] = tx_stop_now &
            ~tx_stop_r;
        set_vec[isf_pkg::BIT_RXSTOP] = ev.rx_halted &
            ~rx_halted_r;
        set_vec[isf_pkg::BIT_DROPMID] =
            (drop_prev_r == isf_pkg::DROP_BELOW) &
            (ev.drop_count == isf_pkg::DROP_MIDPOINT);
        set_vec[isf_pkg::BIT_TXDONE] = ev.tx_done_marked;
        set_vec[isf_pkg::BIT_RXXFER] = ev.rx_xfer_done;
        set_vec[isf_pkg::BIT_TIMER] =
            (timer_prev_r == isf_pkg::TIMER_ZERO) &
            (ev.timer_count == isf_pkg::TIMER_WRAP);
        set_vec[isf_pkg::BIT_POWER] = ev.power_event;
        set_vec[isf_pkg::BIT_TSOVF] = ev.ts_overflow;
        set_vec[isf_pkg::BIT_OVSIZE] = ev.rx_frame_end &
            (ev.rx_frame_len > isf_pkg::OVERSIZE_LEN);
        set_vec[isf_pkg::BIT_RXERR] = ev.rx_error;
        set_vec[isf_pkg::BIT_TXERR] = ev.tx_error;
        set_vec[isf_pkg::BIT_TDOVR] = ev.td_write &
            ev.td_full;
        set_vec[isf_pkg::BIT_TDAVAIL] =
            ev.td_free > ev.td_level;
        set_vec[isf_pkg::BIT_TSFULL] = ev.ts_full;
        set_vec[isf_pkg::BIT_TSLEVEL] =
            ev.ts_used > ev.ts_level;
        set_vec[isf_pkg::BIT_RXDROP] = ev.rx_dropped;
        set_vec[isf_pkg::BIT_RSFULL] = ev.rs_full;
        set_vec[isf_pkg::BIT_RSLEVEL] =
            ev.rs_used > ev.rs_level;
        set_vec[isf_pkg::BIT_GPIO0 +: 3] = ev.gpio_event;
    end

    // Write-one-to-clear, clearable bits only
    assign clr_vec = wr_status ?
                     (bus.wdata & isf_pkg::MASK_CLEAR) :
                     32'h00000000;

    // ------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------
    isf_flag_bank
    #(
        .WIDTH (32),
        .MASK  (isf_pkg::MASK_CLEAR)
    )
    u_bank
    (
        .clock   (clock),
        .rst     (rst),
        .set_vec (set_vec),
        .clr_vec (clr_vec),
        .flags   (status)
    );

    // Status as seen by the host, with live transceiver bit
    always_comb
    begin
        status_view = status & isf_pkg::MASK_IMPL;
        status_view[isf_pkg::BIT_PHY] = phy_r;
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = 32'h00000000;
        case (bus.addr)
            isf_pkg::OFS_STATUS:   rdata_nxt = status_view;
            isf_pkg::OFS_ENABLE:   rdata_nxt = enable_r;
            isf_pkg::OFS_BYTETEST: rdata_nxt = isf_pkg::BYTETEST_VAL;
            default:               rdata_nxt = 32'h00000000;
        endcase
    end

    // Registered read answer, held between reads
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rdata <= 32'h00000000;
        else if (bus.cs & bus.rd)
            rdata <= rdata_nxt;
    end

    // ------------------------------------------------------------
    // Wake and interrupt outputs
    // ------------------------------------------------------------
    // Only a byte-test write wakes the device
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            wake_request <= 1'b0;
        else
            wake_request <= wr_bytetest & low_power;
    end

    // Any enabled flag raised
    assign any_enabled = |(status_view & enable_r);

    // Master, held-off and bypass requests
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            master_irq <= 1'b0;
            held_irq   <= 1'b0;
            power_irq  <= 1'b0;
        end
        else
        begin
            master_irq <= any_enabled;
            held_irq   <= |(status_view & enable_r &
                            ~(32'h1 << isf_pkg::BIT_POWER));
            power_irq  <= status_view[isf_pkg::BIT_POWER] &
                          enable_r[isf_pkg::BIT_POWER];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Common clock and reset for the checks below
    default clocking cb_check @(posedge clock);
    endclocking
    default disable iff (rst);

    a_clear_one: assert property (
        wr_status && bus.wdata[isf_pkg::BIT_RXERR] && !ev.rx_error
        |=> !status[isf_pkg::BIT_RXERR])
        else $error("flag not cleared by write of one");

    a_clear_zero: assert property (
        status[isf_pkg::BIT_TXERR] &&
        !(wr_status && bus.wdata[isf_pkg::BIT_TXERR])
        |=> status[isf_pkg::BIT_TXERR])
        else $error("flag lost without a clearing write");

    a_sw_rise: assert property (
        wr_enable && bus.wdata[isf_pkg::BIT_SW] &&
        !enable_r[isf_pkg::BIT_SW]
        |=> status[isf_pkg::BIT_SW])
        else $error("software flag not set on enable");

    a_rx_halt: assert property (
        $rose(ev.rx_halted) |=> status[isf_pkg::BIT_RXSTOP])
        else $error("receive halted flag missing");

    a_drop_mid: assert property (
        ev.drop_count == isf_pkg::DROP_BELOW ##1
        ev.drop_count == isf_pkg::DROP_MIDPOINT
        |=> status[isf_pkg::BIT_DROPMID])
        else $error("drop midpoint flag missing");

    a_timer_wrap: assert property (
        ev.timer_count == isf_pkg::TIMER_ZERO ##1
        ev.timer_count == isf_pkg::TIMER_WRAP
        |=> status[isf_pkg::BIT_TIMER])
        else $error("timer wrap flag missing");

    a_phy_mirror: assert property (
        ev.phy_event ##1 ev.phy_event
        |=> status_view[isf_pkg::BIT_PHY])
        else $error("transceiver bit not mirrored");

    a_power_set: assert property (
        ev.power_event |=> status[isf_pkg::BIT_POWER])
        else $error("power event flag missing");

    a_wake_only: assert property (
        wake_request |-> $past(wr_bytetest))
        else $error("wake without byte-test write");

    a_power_path: assert property (
        status[isf_pkg::BIT_POWER] && enable_r[isf_pkg::BIT_POWER]
        |=> power_irq && master_irq)
        else $error("power request not delivered");

    a_oversize: assert property (
        ev.rx_frame_end && ev.rx_frame_len == isf_pkg::OVERSIZE_LEN &&
        !status[isf_pkg::BIT_OVSIZE]
        |=> !status[isf_pkg::BIT_OVSIZE])
        else $error("oversize flag at exactly 2048 bytes");

    a_td_overrun: assert property (
        ev.td_write && ev.td_full |=> status[isf_pkg::BIT_TDOVR])
        else $error("transmit overrun flag missing");

    a_gpio_latch: assert property (
        ev.gpio_event[2] |=> status[isf_pkg::BIT_GPIO0 + 2])
        else $error("pin event flag missing");

    a_mask_free: assert property (
        ev.rx_dropped && !enable_r[isf_pkg::BIT_RXDROP]
        |=> status[isf_pkg::BIT_RXDROP])
        else $error("masked source did not set flag");

    a_master_any: assert property (
        ##1 master_irq == $past(any_enabled))
        else $error("master indication mismatch");

    a_reserved_zero: assert property (
        (status_view & ~isf_pkg::MASK_IMPL) == 32'h00000000)
        else $error("reserved status bit set");

    // ------------------------------------------------------------
    // Covers
    // ------------------------------------------------------------
    c_set_clear: cover property (@(posedge clock) disable iff (rst)
        status[isf_pkg::BIT_RXDROP] ##1 wr_status ##1
        !status[isf_pkg::BIT_RXDROP]);

    c_set_wins: cover property (@(posedge clock) disable iff (rst)
        wr_status && bus.wdata[isf_pkg::BIT_RXERR] && ev.rx_error);

    c_wake: cover property (@(posedge clock) disable iff (rst)
        low_power && wr_bytetest ##1 wake_request);

    c_master: cover property (@(posedge clock) disable iff (rst)
        !master_irq ##1 master_irq);

endmodule

//--- tb/isf_host.sv
`timescale 1ns/1ns
module isf_host
(
    // Clock
    input  wire logic         clock,
    // Register port toward the block
    output isf_pkg::isf_bus_t bus
);
    event rd_done;

    // Deselect; stale address and data are scrambled
    task automatic idle(input logic [7:0] a, input logic [31:0] d);
        bus.cs = 1'b0;
        bus.wr = 1'b0;
        bus.rd = 1'b0;
        bus.addr = ~a;
        bus.wdata = ~d;
    endtask

    // One write cycle, held until the taking edge
    task automatic write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        #2;
        bus.cs = 1'b1;
        bus.wr = 1'b1;
        bus.addr = a;
        bus.wdata = d;
        @(posedge clock);
        #2;
        idle(a, d);
    endtask

    // One read cycle; data is settled when rd_done fires
    task automatic read(input logic [7:0] a);
        @(posedge clock);
        #2;
        bus.cs = 1'b1;
        bus.rd = 1'b1;
        bus.addr = a;
        @(posedge clock);
        #2;
        idle(a, bus.wdata);
        -> rd_done;
    endtask

    // Idle from time zero
    initial
    begin
        idle(8'h00, 32'h00000000);
    end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                 clock;
    logic                 rst;
    logic                 low_power;
    isf_pkg::isf_events_t ev;
    isf_pkg::isf_bus_t    bus;
    logic          [31:0] rdata;
    logic                 wake_request;
    logic                 master_irq;
    logic                 held_irq;
    logic                 power_irq;
    logic          [31:0] exp_q[$];
    logic          [31:0] m;
    int                   n_fail;
    int                   total_checks;
    int                   bits[21] = '{21, 20, 17, 16, 15, 14, 13, 10, 9,
                                       8, 7, 6, 4, 3, 2, 1, 0, 25, 24, 23, 19};

    isf_status i_dut (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
                      .ev(ev), .low_power(low_power),
                      .wake_request(wake_request), .master_irq(master_irq),
                      .held_irq(held_irq), .power_irq(power_irq));
    isf_host i_host (.clock(clock), .bus(bus));

    // Clock, 50 ns period
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Quiet event sources
    function automatic isf_pkg::isf_events_t ev_idle();
        isf_pkg::isf_events_t e;
        e = '0;
        e.timer_count = 16'h1234;
        return e;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        i_host.read(a);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.write(a, d);
    endtask

    // Pre-state one cycle, trigger one cycle, then quiet
    task automatic fire(input int b);
        isf_pkg::isf_events_t p;
        isf_pkg::isf_events_t t;
        p = ev_idle();
        t = ev_idle();
        case (b)
            21: t.tx_done_marked = 1'b1;
            20: t.rx_xfer_done = 1'b1;
            17: t.power_event = 1'b1;
            16: t.ts_overflow = 1'b1;
            15:
            begin
                t.rx_frame_end = 1'b1;
                t.rx_frame_len = 14'h0801;
            end
            14: t.rx_error = 1'b1;
            13: t.tx_error = 1'b1;
            10:
            begin
                t.td_write = 1'b1;
                t.td_full = 1'b1;
            end
            9:
            begin
                t.td_level = 8'($urandom_range(0, 254));
                t.td_free = t.td_level + 8'h01;
            end
            8: t.ts_full = 1'b1;
            7:
            begin
                t.ts_level = 8'($urandom_range(0, 254));
                t.ts_used = t.ts_level + 8'h01;
            end
            6: t.rx_dropped = 1'b1;
            4: t.rs_full = 1'b1;
            3:
            begin
                t.rs_level = 8'($urandom_range(0, 254));
                t.rs_used = t.rs_level + 8'h01;
            end
            2, 1, 0: t.gpio_event = 3'(1 << b);
            25:
            begin
                p.stop_tx_req = 1'b1;
                t.stop_tx_req = 1'b1;
                t.tx_halted = 1'b1;
            end
            24: t.rx_halted = 1'b1;
            23:
            begin
                p.drop_count = isf_pkg::DROP_BELOW;
                t.drop_count = isf_pkg::DROP_MIDPOINT;
            end
            19:
            begin
                p.timer_count = isf_pkg::TIMER_ZERO;
                t.timer_count = isf_pkg::TIMER_WRAP;
            end
            default:
            begin
                t.rx_frame_end = 1'b1;
                t.rx_frame_len = isf_pkg::OVERSIZE_LEN;
                t.td_write = 1'b1;
                t.tx_halted = 1'b1;
                t.ts_level = 8'($urandom_range(0, 255));
                t.ts_used = t.ts_level;
                t.td_free = t.ts_level;
                t.td_level = t.ts_level;
            end
        endcase
        @(posedge clock);
        #2 ev = p;
        @(posedge clock);
        #2 ev = t;
        @(posedge clock);
        #2 ev = ev_idle();
    endtask

    task automatic print_verdict();
        if (exp_q.size() != 0)
            n_fail++;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Read data monitor against oldest expectation
    initial
    begin
        forever
        begin
            @(i_host.rd_done);
            check(rdata, exp_q.pop_front(), "rdata");
        end
    end

    // Watchdog
    initial
    begin
        #2000000;
        n_fail++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        rst = 1'b1;
        low_power = 1'b0;
        ev = ev_idle();
        n_fail = 0;
        total_checks = 0;
        void'($urandom(32'ha09a));
        repeat (16) @(posedge clock);
        #2 rst = 1'b0;
        rd(isf_pkg::OFS_STATUS, 32'h00000000);
        rd(isf_pkg::OFS_ENABLE, 32'h00000000);
        rd(isf_pkg::OFS_BYTETEST, isf_pkg::BYTETEST_VAL);
        wr(8'h60, 32'hffffffff);
        rd(8'h60, 32'h00000000);
        $display("test done: reset");
        foreach (bits[i])
        begin
            m = 32'h00000001 << bits[i];
            fire(bits[i]);
            rd(isf_pkg::OFS_STATUS, m);
            wr(isf_pkg::OFS_STATUS, ~m);
            rd(isf_pkg::OFS_STATUS, m);
            wr(isf_pkg::OFS_STATUS, m);
            rd(isf_pkg::OFS_STATUS, 32'h00000000);
        end
        fire(-1);
        rd(isf_pkg::OFS_STATUS, 32'h00000000);
        $display("test done: flags");
        @(posedge clock);
        #2 ev.phy_event = 1'b1;
        repeat (2) @(posedge clock);
        rd(isf_pkg::OFS_STATUS, 32'h00040000);
        wr(isf_pkg::OFS_STATUS, 32'hffffffff);
        rd(isf_pkg::OFS_STATUS, 32'h00040000);
        @(posedge clock);
        #2 ev.phy_event = 1'b0;
        rd(isf_pkg::OFS_STATUS, 32'h00000000);
        wr(isf_pkg::OFS_ENABLE, 32'h80000000);
        rd(isf_pkg::OFS_STATUS, 32'h80000000);
        wr(isf_pkg::OFS_STATUS, 32'h80000000);
        rd(isf_pkg::OFS_STATUS, 32'h00000000);
        $display("test done: phy and software");
        wr(isf_pkg::OFS_ENABLE, 32'h00000040);
        fire(6);
        @(posedge clock);
        #2 check({31'h0, master_irq}, 32'h1, "master");
        check({31'h0, held_irq}, 32'h1, "held");
        check({31'h0, power_irq}, 32'h0, "power");
        wr(isf_pkg::OFS_STATUS, 32'h00000040);
        @(posedge clock);
        #2 check({31'h0, master_irq}, 32'h0, "master off");
        wr(isf_pkg::OFS_ENABLE, 32'h00020000);
        fire(17);
        @(posedge clock);
        #2 check({31'h0, power_irq}, 32'h1, "power on");
        check({31'h0, held_irq}, 32'h0, "held off");
        check({31'h0, master_irq}, 32'h1, "master power");
        wr(isf_pkg::OFS_STATUS, 32'h00020000);
        wr(isf_pkg::OFS_ENABLE, 32'h00000000);
        $display("test done: irq");
        low_power = 1'b1;
        fire(17);
        check({31'h0, wake_request}, 32'h0, "no wake on event");
        wr(isf_pkg::OFS_BYTETEST, $urandom());
        check({31'h0, wake_request}, 32'h1, "wake");
        @(posedge clock);
        #2 check({31'h0, wake_request}, 32'h0, "wake pulse");
        low_power = 1'b0;
        wr(isf_pkg::OFS_BYTETEST, $urandom());
        check({31'h0, wake_request}, 32'h0, "awake");
        rd(isf_pkg::OFS_STATUS, 32'h00020000);
        $display("test done: wake");
        fire(6);
        @(posedge clock);
        #2 rst = 1'b1;
        @(posedge clock);
        #2 rst = 1'b0;
        rd(isf_pkg::OFS_STATUS, 32'h00000000);
        $display("test done: second reset");
        @(posedge clock);
        print_verdict();
    end
endmodule
